//--- rtl/gsd_serial_out.sv
// Gage serial data output: snapshot crossing and open-drain shifter
// Function
// - Gage generates the link clock and drives data and clock lines.
// - A transfer is 52 bits: 13 digits of four bits each.
// - Digits go first to thirteenth, each least significant bit first.
// - Held request repeats complete transfers about every 95 ms.
// - Inputs idle high by pull-up; asserted only by pulling low.
`timescale 1ns/1ps
module gsd_serial_out #(
  parameter int unsigned REPEAT_CYCLES = gsd_pkg::REPEAT_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic link_clock,
  input wire gsd_pkg::gsd_frame_type meas_value,
  input wire logic request_in_b,
  input wire logic origin_set_input,
  output logic origin_cmd,
  output logic data_out,
  output logic data_oe_b,
  output logic sync_clock_out,
  output logic sync_clock_oe_b
);
  import gsd_pkg::*;

  // ---------------------------------------------------------------
  // Core domain: origin command and snapshot handshake
  // ---------------------------------------------------------------
  logic origin_sync;
  logic origin_prev_q;
  logic origin_cmd_q;
  gsd_frame_type hold_q;
  logic req_tgl_q;
  logic ack_tgl_core;
  logic ack_tgl_link_q;

  gsd_sync2 #(.RST_VAL(PIN_IDLE)) u_sync_origin (
    .clock(clock),
    .rst_b(rst_b),
    .din(origin_set_input),
    .dout(origin_sync)
  );

  // Falling edge of the pulled-up input is the command
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      origin_prev_q <= PIN_IDLE;
      origin_cmd_q <= 1'b0;
    end else begin
      origin_prev_q <= origin_sync;
      origin_cmd_q <= origin_prev_q && !origin_sync;
    end
  end

  assign origin_cmd = origin_cmd_q;

  gsd_sync2 #(.RST_VAL(TOGGLE_RST)) u_sync_ack (
    .clock(clock),
    .rst_b(rst_b),
    .din(ack_tgl_link_q),
    .dout(ack_tgl_core)
  );

  // Hold register only changes once the link side has taken it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_q <= '0;
      req_tgl_q <= TOGGLE_RST;
    end else if (ack_tgl_core == req_tgl_q) begin
      hold_q <= meas_value;
      req_tgl_q <= !req_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: reset, snapshot capture, request sensing
  // ---------------------------------------------------------------
  logic lrst_b;
  logic req_tgl_link;
  logic req_tgl_seen_q;
  logic request_sync;
  gsd_frame_type latest_q;

  gsd_sync2 #(.RST_VAL(1'b0)) u_sync_lrst (
    .clock(link_clock),
    .rst_b(1'b1),
    .din(rst_b),
    .dout(lrst_b)
  );

  gsd_sync2 #(.RST_VAL(TOGGLE_RST)) u_sync_req_tgl (
    .clock(link_clock),
    .rst_b(lrst_b),
    .din(req_tgl_q),
    .dout(req_tgl_link)
  );

  gsd_sync2 #(.RST_VAL(PIN_IDLE)) u_sync_request (
    .clock(link_clock),
    .rst_b(lrst_b),
    .din(request_in_b),
    .dout(request_sync)
  );

  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      req_tgl_seen_q <= TOGGLE_RST;
      ack_tgl_link_q <= TOGGLE_RST;
      latest_q <= '0;
    end else if (req_tgl_link != req_tgl_seen_q) begin
      req_tgl_seen_q <= req_tgl_link;
      ack_tgl_link_q <= req_tgl_link;
      latest_q <= hold_q;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: transfer sequencer
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(REPEAT_CYCLES - 1);

  gsd_link_state_type state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [5:0] bit_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] snap_q;
  gsd_pins_type pins_q;

  logic cnt_done;
  assign cnt_done = (state_q == L_LEAD) ? (cnt_q == LEAD_LAST) :
                    (state_q == L_GAP) ? (cnt_q == GAP_LAST) :
                    (cnt_q == HALF_LAST);

  // Active-low request starts a frame; nothing is sent otherwise
  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      state_q <= L_IDLE;
    end else begin
      case (state_q)
        L_IDLE: begin
          if (!request_sync) begin
            state_q <= L_LEAD;
          end
        end
        L_LEAD: begin
          if (cnt_done) begin
            state_q <= L_HIGH;
          end
        end
        L_HIGH: begin
          if (cnt_done) begin
            state_q <= L_LOW;
          end
        end
        L_LOW: begin
          if (cnt_done) begin
            state_q <= (bit_q == LAST_BIT_IDX) ? L_GAP : L_HIGH;
          end
        end
        L_GAP: begin
          // Spacing lets a held request repeat at the set interval
          if (cnt_done) begin
            state_q <= L_IDLE;
          end
        end
        default: begin
          state_q <= L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      cnt_q <= '0;
    end else if (state_q == L_IDLE || cnt_done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Snapshot taken at frame start so a frame never mixes two readings
  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      shift_q <= '0;
      snap_q <= '0;
      bit_q <= '0;
    end else if (state_q == L_IDLE && !request_sync) begin
      shift_q <= latest_q;
      snap_q <= latest_q;
      bit_q <= '0;
    end else if (state_q == L_LOW && cnt_done) begin
      shift_q <= {1'b0, shift_q[FRAME_BITS-1:1]};
      bit_q <= bit_q + 6'd1;
    end
  end

  // Data changes only with clock released, held through low phase
  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      pins_q <= PINS_RELEASED;
    end else begin
      case (state_q)
        L_HIGH: begin
          pins_q.data_oe_b <= shift_q[0];
          pins_q.clock_oe_b <= !cnt_done;
        end
        L_LOW: begin
          pins_q.clock_oe_b <= cnt_done;
          if (cnt_done && bit_q == LAST_BIT_IDX) begin
            pins_q.data_oe_b <= 1'b1;
          end
        end
        default: begin
          pins_q <= PINS_RELEASED;
        end
      endcase
    end
  end

  // Open drain: pull low or release, never drive high
  assign data_out = 1'b0;
  assign sync_clock_out = 1'b0;
  assign data_oe_b = pins_q.data_oe_b;
  assign sync_clock_oe_b = pins_q.clock_oe_b;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic first_bit_q;
  always_ff @(posedge link_clock) begin
    if (!lrst_b) begin
      first_bit_q <= 1'b0;
    end else begin
      first_bit_q <= (state_q == L_LEAD) && cnt_done;
    end
  end

  AST_CLOCK_IN_FRAME: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    !sync_clock_oe_b |-> $past(state_q) inside {L_HIGH, L_LOW})
    else $error("Clock pulled low outside a frame");

  AST_DATA_STABLE_LOW: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    (!sync_clock_oe_b && $past(!sync_clock_oe_b)) |-> $stable(data_oe_b))
    else $error("Data moved while clock low");

  AST_FRAME_BITS: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    (state_q == L_LOW && $past(state_q) == L_LOW) ##1 (state_q == L_GAP)
    |-> $past(bit_q) == LAST_BIT_IDX)
    else $error("Frame length not 52 bits");

  AST_FIRST_BIT_LSB: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    first_bit_q |=> data_oe_b == snap_q[0])
    else $error("First bit is not lsb of first digit");

  AST_IDLE_RELEASED: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    (state_q == L_IDLE && $past(state_q) == L_IDLE)
    |-> data_oe_b && sync_clock_oe_b)
    else $error("Line held low while idle");

  AST_GAP_LENGTH: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    (state_q == L_GAP && $past(state_q) == L_GAP) |-> cnt_q <= GAP_LAST)
    else $error("Repeat gap overran");

  AST_REQUEST_STARTS: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    (state_q == L_IDLE && !request_sync) |=> state_q == L_LEAD)
    else $error("Request not acted on");

  AST_CLOCK_LOW_WIDTH: assert property (
    @(posedge link_clock) disable iff (!lrst_b)
    $fell(sync_clock_oe_b) |-> (!sync_clock_oe_b)[*8])
    else $error("Clock low phase too short");

  AST_ORIGIN_CMD: assert property (
    @(posedge clock) disable iff (!rst_b)
    (origin_prev_q && !origin_sync) |=> origin_cmd ##1 !origin_cmd)
    else $error("Origin command not a single pulse");

endmodule

//--- rtl/gsd_pkg.sv
// Package: constants and types for the gage serial data output
package gsd_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int DIGIT_BITS = 4;
  localparam int DIGIT_COUNT = 13;
  localparam int FRAME_BITS = DIGIT_BITS * DIGIT_COUNT;
  localparam logic [5:0] LAST_BIT_IDX = 6'(FRAME_BITS - 1);

  typedef logic [DIGIT_BITS-1:0] gsd_digit_type;
  // Element 0 is the first digit sent; bit 0 of it goes out first
  typedef gsd_digit_type [DIGIT_COUNT-1:0] gsd_frame_type;

  // Released (high) or pulled low, per open-drain line
  typedef struct packed {
    logic data_oe_b;
    logic clock_oe_b;
  } gsd_pins_type;

  localparam gsd_pins_type PINS_RELEASED = '{data_oe_b: 1'b1,
                                             clock_oe_b: 1'b1};

  // ---------------------------------------------------------------
  // Link timing, counted on the link clock
  // ---------------------------------------------------------------
  localparam int LINK_CLK_NS = 48;
  localparam int CORE_CLK_NS = 10;
  // Wait from sensed request to first bit (least time)
  localparam int LEAD_NS = 15000;
  localparam int LEAD_CYCLES = (LEAD_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  // Each clock phase (least time)
  localparam int HALF_BIT_NS = 500;
  localparam int HALF_BIT_CYCLES =
    (HALF_BIT_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  // Repeat interval while request is held (longest time)
  localparam int REPEAT_MS = 95;
  localparam int REPEAT_CYCLES_DEF = (REPEAT_MS * 1000000) / LINK_CLK_NS;

  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(LEAD_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_BIT_CYCLES - 1);

  // Reset values
  localparam logic TOGGLE_RST = 1'b0;
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    L_IDLE,
    L_LEAD,
    L_HIGH,
    L_LOW,
    L_GAP
  } gsd_link_state_type;

endpackage

//--- rtl/gsd_sync2.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module gsd_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);

  logic meta_q;
  logic sync_q;

  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

//--- tb/gsd_far_model.sv
// Far-side counter model: requests frames and shifts in the serial bits
`timescale 1ns/1ps
module gsd_far_model (
  input wire logic link_clock,
  input wire logic rst_b,
  input wire logic sck_line,
  input wire logic sda_line,
  input wire logic req_go,
  input wire logic req_hold,
  input wire logic org_go,
  output logic request_in_b,
  output logic origin_set_input,
  output logic [51:0] rx_bits,
  output int rx_cnt,
  output int frame_cnt
);
  logic seen_clk_q;

  // ---------------------------------------------------------------
  // Request and origin pins, pulled low only
  // ---------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (!rst_b || !req_go) begin
      seen_clk_q <= 1'b0;
    end else if (!sck_line && !req_hold) begin
      seen_clk_q <= 1'b1;
    end
  end

  // Released pins read high through the pull-ups
  assign request_in_b = !(req_go && !seen_clk_q);
  assign origin_set_input = !org_go;

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  initial begin
    rx_cnt = 0;
    frame_cnt = 0;
    rx_bits = '0;
  end

  // Data is only trusted once the clock line is low
  always @(negedge sck_line) begin
    rx_bits = {sda_line, rx_bits[51:1]};
    rx_cnt = rx_cnt + 1;
    if (rx_cnt % 52 == 0) begin
      frame_cnt = frame_cnt + 1;
    end
  end
endmodule

//--- tb/gsd_serial_out_bench.sv
// Bench for the gage serial data output
`timescale 1ns/1ps
module gsd_serial_out_bench;
  import gsd_pkg::*;
  localparam int REP = 50;
  logic clock, link_clock, rst_b, origin_cmd;
  logic data_out, data_oe_b, sync_clock_out, sync_clock_oe_b;
  logic request_in_b, origin_set_input, req_go, req_hold, org_go;
  gsd_frame_type meas_value;
  logic [51:0] rx_bits;
  int rx_cnt, frame_cnt, error_cnt, n_tests, cyc;
  wire sck_line = sync_clock_oe_b ? 1'b1 : sync_clock_out;
  wire sda_line = data_oe_b ? 1'b1 : data_out;

  gsd_serial_out #(.REPEAT_CYCLES(REP)) i_gsd_serial_out (
    .clock(clock), .rst_b(rst_b), .link_clock(link_clock),
    .meas_value(meas_value), .request_in_b(request_in_b),
    .origin_set_input(origin_set_input), .origin_cmd(origin_cmd),
    .data_out(data_out), .data_oe_b(data_oe_b),
    .sync_clock_out(sync_clock_out), .sync_clock_oe_b(sync_clock_oe_b)
  );

  gsd_far_model i_gsd_far_model (
    .link_clock(link_clock), .rst_b(rst_b), .sck_line(sck_line),
    .sda_line(sda_line), .req_go(req_go), .req_hold(req_hold),
    .org_go(org_go), .request_in_b(request_in_b),
    .origin_set_input(origin_set_input), .rx_bits(rx_bits),
    .rx_cnt(rx_cnt), .frame_cnt(frame_cnt)
  );

  // ---------------------------------------------------------------
  // Clocks and timeout
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Phase offset keeps the two domains unrelated
  initial begin
    link_clock = 1'b0;
    #7.3;
    forever #24 link_clock = ~link_clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [51:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_frames(input int n);
    int goal;
    goal = frame_cnt + n;
    for (int k = 0; k < 30000 && frame_cnt < goal; k++) @(posedge clock);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic origin_pulse();
    int n;
    n = 0;
    org_go <= 1'b1;
    for (int k = 0; k < 60; k++) begin
      @(posedge clock);
      if (k == 40) org_go <= 1'b0;
      #1 if (origin_cmd === 1'b1) n++;
    end
    // Back onto the rising edge so the next task drives there
    @(posedge clock);
    chk("origin pulses", 52'(n), 52'd1);
  endtask

  task automatic one_frame(input logic [51:0] pat);
    int c0;
    meas_value <= pat;
    // Let the reading cross into the link snapshot first
    repeat (60) @(posedge clock);
    c0 = rx_cnt;
    req_go <= 1'b1;
    wait_frames(1);
    req_go <= 1'b0;
    chk("frame bits", rx_bits, pat);
    chk("bit count", 52'(rx_cnt - c0), 52'd52);
    repeat (2000) @(posedge clock);
    chk("unasked bits", 52'(rx_cnt - c0), 52'd52);
    chk("lines released", 52'({data_oe_b, sync_clock_oe_b}), 52'h3);
  endtask

  task automatic repeat_frames();
    int f0;
    f0 = frame_cnt;
    req_hold <= 1'b1;
    req_go <= 1'b1;
    wait_frames(3);
    req_go <= 1'b0;
    req_hold <= 1'b0;
    chk("held frames", 52'(frame_cnt - f0), 52'd3);
    chk("last held frame", rx_bits, 52'ha_5a5a_c3c3_0ff1);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    req_go = 1'b0;
    req_hold = 1'b0;
    org_go = 1'b0;
    meas_value = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clock);
    // Link side also needs four of its own edges in reset
    repeat (4) @(posedge link_clock);
    @(posedge clock);
    rst_b <= 1'b1;
    // Scaled settling wait before either input is pulled low
    repeat (30) @(posedge clock);
    chk("idle pins", 52'({data_oe_b, sync_clock_oe_b, origin_cmd}),
        52'h6);
    origin_pulse();
    one_frame(52'h1_2345_6789_abcd);
    one_frame(52'ha_5a5a_c3c3_0ff1);
    repeat_frames();
    results();
  end
endmodule
